// ==== inc/scp_pkg.sv ====
// Shared constants of the serial command port
package scp_pkg;
   // ==============================================================
   // Frame layout
   localparam int ID_W = 6;
   localparam int WORD_W = 16;
   localparam int ROW_W = 8;
   localparam logic [4:0] RS_BIT = 5'h07;
   localparam logic [4:0] RW_BIT = 5'h08;
   localparam logic [4:0] START_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam logic [4:0] LAST_IDX = 5'h17;
   localparam logic [7:0] STATUS_LOW = 8'h00;
   // ==============================================================
   // Reset values
   localparam logic [4:0] SYNC_RST = 5'h1F;
   localparam logic [7:0] INDEX_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   // ==============================================================
   // Timing, clock 200 MHz
   localparam int CLK_PERIOD_PS = 5000;
   localparam int RST_TIME_NS = 10;
   localparam int RST_TIME_US = 10;
   localparam int RST_CYC =
      (RST_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [11:0] SCK_HALF_CYC = 12'h00C;
   // ==============================================================
   // Controller register offsets and fields
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TXDATA = 8'h04;
   localparam logic [7:0] OFS_RXDATA = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_CHIPADDR = 8'h10;
   localparam int CTRL_START = 0;
   localparam int CTRL_RS = 1;
   localparam int CTRL_RW = 2;
   localparam int CTRL_RESET = 3;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam logic [5:0] CHIPADDR_RST = 6'h00;
endpackage : scp_pkg

// ==== inc/scp_link_if.sv ====
// Serial link between host controller and device
`timescale 1ns/1ps
`default_nettype none
interface scp_link_if;
   logic serial_select_n;
   logic serial_clk;
   logic serial_din;
   logic serial_dout;
   logic serial_dout_oe;
   logic reset_n_pin;
   modport device (
      input serial_select_n, serial_clk, serial_din, reset_n_pin,
      output serial_dout, serial_dout_oe
   );
   modport host (
      output serial_select_n, serial_clk, serial_din, reset_n_pin,
      input serial_dout, serial_dout_oe
   );
endinterface : scp_link_if
`default_nettype wire

// ==== design/scp_sync.sv ====
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module scp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;
   // ==============================================================
   // Only the second stage is visible outside
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= RST;
         q_reg <= RST;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end
   assign q = q_reg;
endmodule : scp_sync
`default_nettype wire

// ==== design/scp_device.sv ====
// Device end of the serial command port with its reset front end
`timescale 1ns/1ps
`default_nettype none
module scp_device #(
   // Identity codes: values are arbitrary
   parameter logic [5:0] ID_PRIMARY = 6'h2A,
   parameter logic [5:0] ID_SECONDARY = 6'h15
) (
   input wire logic hclk,
   input wire logic hresetn,
   scp_link_if.device link,
   input wire logic table_select_pin,
   input wire logic [scp_pkg::ROW_W-1:0] row_position,
   output logic [7:0] index_reg,
   output logic [7:0] cmd_index_reg,
   output logic [scp_pkg::WORD_W-1:0] cmd_word_reg,
   output logic cmd_strobe_reg,
   output logic selected_reg,
   output logic in_reset_reg
);
   import scp_pkg::*;
   logic cs_s, sck_s, din_s, rst_pin_s, tsel_s;
   logic cs_d_reg, sck_d_reg;
   logic cs_fall, cs_rise, sck_rise, sck_fall;
   logic pin_rst;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic [WORD_W-1:0] rx_reg;
   logic [WORD_W-1:0] tx_reg;
   logic [WORD_W-1:0] tx_next;
   logic rs_reg, rw_reg;
   logic sdo_reg, sdo_oe_reg;
   logic [ID_W-1:0] my_id;
   logic id_ok;
   logic exec;
   // ==============================================================
   // Pin synchronisers, reset to the pulled-up level
   scp_sync #(.W(5), .RST(SYNC_RST)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({link.serial_select_n, link.serial_clk, link.serial_din,
          link.reset_n_pin, table_select_pin}),
      .q({cs_s, sck_s, din_s, rst_pin_s, tsel_s})
   );
   // Pulse must be long enough to pass the synchroniser; the host
   // keeps it low far longer than that.
   assign pin_rst = !rst_pin_s;
   // ==============================================================
   // Edge detection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cs_d_reg <= 1'b1;
         sck_d_reg <= 1'b1;
      end else begin
         cs_d_reg <= cs_s;
         sck_d_reg <= sck_s;
      end
   end
   assign cs_fall = cs_d_reg && !cs_s;
   assign cs_rise = !cs_d_reg && cs_s;
   assign sck_rise = !sck_d_reg && sck_s;
   assign sck_fall = sck_d_reg && !sck_s;
   assign my_id = tsel_s ? ID_PRIMARY : ID_SECONDARY;
   assign cnt_next = cnt_reg + 5'h01;
   assign id_ok = ({rx_reg[ID_W-2:0], din_s} == my_id);
   assign exec = selected_reg && sck_rise && !rw_reg
      && (cnt_next == FRAME_BITS);
   // ==============================================================
   // Transfer state: selection and bit count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         selected_reg <= 1'b0;
         cnt_reg <= 5'h00;
      end else if (pin_rst) begin
         selected_reg <= 1'b0;
         cnt_reg <= 5'h00;
      end else if (cs_rise) begin
         // Partial words die here with the count
         selected_reg <= 1'b0;
         cnt_reg <= 5'h00;
      end else if (cs_fall) begin
         selected_reg <= 1'b1;
         cnt_reg <= 5'h00;
      end else if (selected_reg && sck_rise) begin
         if (cnt_next == FRAME_BITS) begin
            // Further words may follow in the same frame
            cnt_reg <= START_BITS;
         end else begin
            cnt_reg <= cnt_next;
         end
         if (cnt_next == 5'(ID_W) && !id_ok) begin
            selected_reg <= 1'b0;
         end
      end
   end
   // ==============================================================
   // Start-byte control bits; cleared per frame so a stale
   // direction cannot enable the output of the next frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rs_reg <= 1'b0;
         rw_reg <= 1'b0;
      end else if (pin_rst || cs_fall) begin
         rs_reg <= 1'b0;
         rw_reg <= 1'b0;
      end else if (selected_reg && sck_rise) begin
         if (cnt_next == RS_BIT) begin
            rs_reg <= din_s;
         end
         if (cnt_next == RW_BIT) begin
            rw_reg <= din_s;
         end
      end
   end
   // ==============================================================
   // Receive shifter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_reg <= WORD_RST;
      end else if (pin_rst || cs_fall) begin
         rx_reg <= WORD_RST;
      end else if (selected_reg && sck_rise) begin
         rx_reg <= {rx_reg[WORD_W-2:0], din_s};
      end
   end
   // ==============================================================
   // Execution of complete words; index writes and instruction
   // writes are kept apart
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         index_reg <= INDEX_RST;
      end else if (pin_rst) begin
         index_reg <= INDEX_RST;
      end else if (exec && !rs_reg) begin
         index_reg <= {rx_reg[6:0], din_s};
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_index_reg <= INDEX_RST;
         cmd_word_reg <= WORD_RST;
         cmd_strobe_reg <= 1'b0;
      end else if (pin_rst) begin
         cmd_index_reg <= INDEX_RST;
         cmd_word_reg <= WORD_RST;
         cmd_strobe_reg <= 1'b0;
      end else begin
         cmd_strobe_reg <= exec && rs_reg;
         if (exec && rs_reg) begin
            cmd_index_reg <= index_reg;
            cmd_word_reg <= {rx_reg[WORD_W-2:0], din_s};
         end
      end
   end
   // ==============================================================
   // Transmit path, launched on falling clock edges
   always_comb begin
      if (cnt_reg == START_BITS) begin
         // Instruction reads are not defined; they return zero
         tx_next = rs_reg ? WORD_RST : {row_position, STATUS_LOW};
      end else begin
         tx_next = {tx_reg[WORD_W-2:0], 1'b0};
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_reg <= WORD_RST;
         sdo_reg <= 1'b0;
         sdo_oe_reg <= 1'b0;
      end else if (pin_rst || cs_rise || !selected_reg) begin
         tx_reg <= WORD_RST;
         sdo_reg <= 1'b0;
         sdo_oe_reg <= 1'b0;
      end else if (sck_fall && rw_reg && cnt_reg >= START_BITS) begin
         tx_reg <= tx_next;
         sdo_reg <= tx_next[WORD_W-1];
         sdo_oe_reg <= 1'b1;
      end
   end
   assign link.serial_dout = sdo_reg;
   assign link.serial_dout_oe = sdo_oe_reg;
   // ==============================================================
   // Reset indication
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_reset_reg <= 1'b1;
      end else begin
         in_reset_reg <= pin_rst;
      end
   end
endmodule : scp_device
`default_nettype wire

// ==== design/scp_host.sv ====
// Host controller end of the serial command port, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module scp_host (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   scp_link_if.host link
);
   import scp_pkg::*;
   typedef enum logic [2:0] {
      ST_IDLE, ST_RESET, ST_SETUP, ST_LOW, ST_HIGH, ST_END, ST_GAP
   } scp_state_t;
   scp_state_t state_reg;
   logic [11:0] timer_reg;
   logic [4:0] bit_reg;
   logic [FRAME_BITS-1:0] frame_reg;
   logic [WORD_W-1:0] rx_reg;
   logic [WORD_W-1:0] txdata_reg;
   logic [5:0] chipaddr_reg;
   logic done_reg;
   logic ap_wr_reg;
   logic [7:0] ap_addr_reg;
   logic cs_reg, sck_reg, din_reg, rstn_reg;
   logic hrdy_reg;
   logic [31:0] hrdata_reg;
   logic sdo_s;
   logic wr_ctrl, tdone, finish, ap_take;
   logic [31:0] rd_mux;
   scp_sync #(.W(1), .RST(1'b0)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(link.serial_dout && link.serial_dout_oe),
      .q(sdo_s)
   );
   // ==============================================================
   // AHB-Lite slave, zero wait states
   assign ap_take = hsel && hready && htrans[1];
   assign wr_ctrl = ap_wr_reg && (ap_addr_reg == OFS_CTRL);
   always_comb begin
      case (haddr[7:0])
         OFS_TXDATA: rd_mux = {16'h0000, txdata_reg};
         OFS_RXDATA: rd_mux = {16'h0000, rx_reg};
         OFS_STATUS: rd_mux = {30'h0, done_reg,
                               state_reg != ST_IDLE};
         OFS_CHIPADDR: rd_mux = {26'h0, chipaddr_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_reg <= 1'b0;
         ap_addr_reg <= 8'h00;
         hrdata_reg <= 32'h00000000;
         hrdy_reg <= 1'b0;
      end else begin
         hrdy_reg <= 1'b1;
         ap_wr_reg <= ap_take && hwrite;
         ap_addr_reg <= haddr[7:0];
         if (ap_take && !hwrite) begin
            hrdata_reg <= rd_mux;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txdata_reg <= WORD_RST;
         chipaddr_reg <= CHIPADDR_RST;
      end else if (ap_wr_reg) begin
         if (ap_addr_reg == OFS_TXDATA) begin
            txdata_reg <= hwdata[WORD_W-1:0];
         end
         if (ap_addr_reg == OFS_CHIPADDR) begin
            chipaddr_reg <= hwdata[5:0];
         end
      end
   end
   // Completion flag: a finish in the clearing cycle still sets it
   assign finish = tdone && (state_reg == ST_GAP || state_reg == ST_RESET);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_reg <= 1'b0;
      end else if (finish) begin
         done_reg <= 1'b1;
      end else if (ap_wr_reg && ap_addr_reg == OFS_STATUS
                   && hwdata[STAT_DONE]) begin
         done_reg <= 1'b0;
      end
   end
   // ==============================================================
   // Link sequencer; the link clock is divided from hclk
   assign tdone = (timer_reg == 12'h000);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         timer_reg <= 12'h000;
         bit_reg <= 5'h00;
         frame_reg <= '0;
         rx_reg <= WORD_RST;
         cs_reg <= 1'b1;
         sck_reg <= 1'b1;
         din_reg <= 1'b1;
         rstn_reg <= 1'b1;
      end else begin
         if (!tdone) begin
            timer_reg <= timer_reg - 12'h001;
         end
         case (state_reg)
            ST_IDLE: begin
               if (wr_ctrl && hwdata[CTRL_RESET]) begin
                  rstn_reg <= 1'b0;
                  timer_reg <= 12'(RST_CYC - 1);
                  state_reg <= ST_RESET;
               end else if (wr_ctrl && hwdata[CTRL_START]) begin
                  cs_reg <= 1'b0;
                  sck_reg <= 1'b0;
                  frame_reg <= {chipaddr_reg, hwdata[CTRL_RS],
                                hwdata[CTRL_RW], txdata_reg};
                  bit_reg <= 5'h00;
                  timer_reg <= SCK_HALF_CYC;
                  state_reg <= ST_SETUP;
               end
            end
            ST_RESET: begin
               if (tdone) begin
                  rstn_reg <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_SETUP: begin
               if (tdone) begin
                  din_reg <= frame_reg[FRAME_BITS-1];
                  timer_reg <= SCK_HALF_CYC;
                  state_reg <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (tdone) begin
                  sck_reg <= 1'b1;
                  rx_reg <= {rx_reg[WORD_W-2:0], sdo_s};
                  timer_reg <= SCK_HALF_CYC;
                  state_reg <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (tdone) begin
                  sck_reg <= 1'b0;
                  timer_reg <= SCK_HALF_CYC;
                  if (bit_reg == LAST_IDX) begin
                     state_reg <= ST_END;
                  end else begin
                     bit_reg <= bit_reg + 5'h01;
                     frame_reg <= {frame_reg[FRAME_BITS-2:0], 1'b0};
                     din_reg <= frame_reg[FRAME_BITS-2];
                     state_reg <= ST_LOW;
                  end
               end
            end
            ST_END: begin
               if (tdone) begin
                  // Data holds through the closing clock rise
                  cs_reg <= 1'b1;
                  sck_reg <= 1'b1;
                  timer_reg <= SCK_HALF_CYC;
                  state_reg <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (tdone) begin
                  din_reg <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
   assign hreadyout = hrdy_reg;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign link.serial_select_n = cs_reg;
   assign link.serial_clk = sck_reg;
   assign link.serial_din = din_reg;
   assign link.reset_n_pin = rstn_reg;
endmodule : scp_host
`default_nettype wire

// ==== tb/scp_link_assertions.sv ====
// Protocol checker on the serial link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module scp_link_assertions
   import scp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic serial_select_n,
   input wire logic serial_clk,
   input wire logic serial_din,
   input wire logic serial_dout,
   input wire logic serial_dout_oe,
   input wire logic reset_n_pin
);
   logic sck_d;
   logic [4:0] rise_cnt;
   logic [11:0] low_cnt;
   // ===========================================================
   // Helper counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sck_d <= 1'b1;
         rise_cnt <= 5'h00;
      end else begin
         sck_d <= serial_clk;
         if (serial_select_n)
            rise_cnt <= 5'h00;
         else if (serial_clk && !sck_d)
            rise_cnt <= rise_cnt + 5'h01;
      end
   end
   // Saturation not needed: the pulse of RST_CYC cycles stays below the counter range
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         low_cnt <= 12'h000;
      else
         low_cnt <= reset_n_pin ? 12'h000 : low_cnt + 12'h001;
   end
   // ===========================================================
   // Sequences and properties
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_sel_idle;
      serial_select_n [*8];
   endsequence
   sequence s_clk_high;
      serial_clk [*8];
   endsequence
   sequence s_clk_low;
      !serial_clk [*8];
   endsequence
   a_idle_clk_high: assert property (serial_select_n |-> serial_clk)
      else $error("Link clock low while deselected");
   a_sel_gap: assert property ($rose(serial_select_n) |-> s_sel_idle)
      else $error("Select gap between frames too short");
   a_sel_lead: assert property ($fell(serial_select_n) |-> s_clk_low)
      else $error("Link clock rose too soon after select");
   a_clk_high_half: assert property ($rose(serial_clk) |-> s_clk_high)
      else $error("Link clock high phase too short");
   a_clk_low_half: assert property ($fell(serial_clk) |-> s_clk_low)
      else $error("Link clock low phase too short");
   a_din_setup: assert property ($rose(serial_clk)
      |-> $stable(serial_din))
      else $error("Data in changed at sampling edge");
   a_dout_launch: assert property (serial_dout_oe
      && $past(serial_dout_oe) && !$stable(serial_dout) |-> !serial_clk)
      else $error("Data out changed while clock high");
   a_oe_release: assert property (s_sel_idle |-> !serial_dout_oe)
      else $error("Data out driven after deselect");
   a_oe_first_bit: assert property ($rose(serial_dout_oe)
      |-> rise_cnt == START_BITS)
      else $error("Device drove data out before ninth clock");
   a_frame_len: assert property ($rose(serial_select_n)
      |-> rise_cnt == FRAME_BITS)
      else $error("Frame did not carry 24 clocks");
   a_reset_width: assert property ($rose(reset_n_pin)
      |-> int'(low_cnt) >= RST_CYC - 1)
      else $error("Reset pin pulse too short");
endmodule : scp_link_assertions
`default_nettype wire

// ==== tb/serial_command_port_test.sv ====
// Self-checking bench joining the host and device ends of the port
`timescale 1ns/1ps
`default_nettype none
module serial_command_port_test;
   import scp_pkg::*;
   localparam logic [5:0] ID_A = 6'h2A; // Arbitrary identity code
   localparam logic [5:0] ID_B = 6'h15; // Arbitrary identity code
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic table_select_pin, cmd_strobe_reg, selected_reg, in_reset_reg;
   logic [7:0] row_position, index_reg, cmd_index_reg;
   logic [15:0] cmd_word_reg;
   int miscompares, comparisons, strobes, resets_seen;
   scp_link_if link ();
   scp_host u_scp_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .link(link.host));
   scp_device #(.ID_PRIMARY(ID_A), .ID_SECONDARY(ID_B)) u_scp_device (
      .hclk(hclk), .hresetn(hresetn), .link(link.device),
      .table_select_pin(table_select_pin), .row_position(row_position),
      .index_reg(index_reg), .cmd_index_reg(cmd_index_reg),
      .cmd_word_reg(cmd_word_reg), .cmd_strobe_reg(cmd_strobe_reg),
      .selected_reg(selected_reg), .in_reset_reg(in_reset_reg));
   scp_link_assertions u_scp_link_assertions (.hclk(hclk),
      .hresetn(hresetn), .serial_select_n(link.serial_select_n),
      .serial_clk(link.serial_clk), .serial_din(link.serial_din),
      .serial_dout(link.serial_dout),
      .serial_dout_oe(link.serial_dout_oe),
      .reset_n_pin(link.reset_n_pin));
   // ===========================================================
   // Clock and monitors
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (cmd_strobe_reg === 1'b1)
         strobes++;
      if (in_reset_reg === 1'b1)
         resets_seen++;
   end
   // ===========================================================
   // Checking and bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic timed_out();
      miscompares++;
      $display("MISMATCH at %0t: wait ran out", $time);
      give_verdict();
   endtask : timed_out
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1)
         timed_out();
   endtask : wait_ready
   task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rdata = hrdata;
   endtask : ahb
   task automatic poll(input int pos, input logic val, input int lim);
      int n;
      n = 0;
      do begin
         ahb(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (rdata[pos] !== val && n < lim);
      if (rdata[pos] !== val)
         timed_out();
   endtask : poll
   task automatic frame(input logic [5:0] adr, input logic rs,
      input logic rw, input logic [15:0] d);
      ahb(1'b1, OFS_CHIPADDR, {26'h0, adr});
      ahb(1'b1, OFS_TXDATA, {16'h0, d});
      // Done is sticky, and a finished pin reset sets it too
      ahb(1'b1, OFS_STATUS, 32'h2);
      ahb(1'b1, OFS_CTRL, {29'h0, rw, rs, 1'b1});
      poll(STAT_DONE, 1'b1, 400);
   endtask : frame
   // ===========================================================
   // Scenarios
   task automatic t_registers();
      ahb(1'b0, OFS_STATUS, 32'h0);
      check(rdata, 32'h0);
      check(32'(hresp), 32'h0);
      ahb(1'b1, OFS_CHIPADDR, 32'h3F);
      ahb(1'b0, OFS_CHIPADDR, 32'h0);
      check(rdata, 32'h3F);
      ahb(1'b1, 8'h40, 32'hFFFF);
      ahb(1'b0, 8'h40, 32'h0);
      check(rdata, 32'h0);
   endtask : t_registers
   task automatic t_writes();
      int n;
      n = strobes;
      frame(ID_A, 1'b0, 1'b0, 16'h12A5);
      check(32'(index_reg), 32'hA5);
      check(32'(strobes - n), 32'h0);
      frame(ID_A, 1'b1, 1'b0, 16'hBEEF);
      check(32'(cmd_word_reg), 32'hBEEF);
      check(32'(cmd_index_reg), 32'hA5);
      check(32'(strobes - n), 32'h1);
      frame(ID_B, 1'b1, 1'b0, 16'h1234);
      check(32'(cmd_word_reg), 32'hBEEF);
      check(32'(strobes - n), 32'h1);
      frame(ID_A ^ 6'h01, 1'b1, 1'b0, 16'h1234);
      check(32'(cmd_word_reg), 32'hBEEF);
      table_select_pin <= 1'b0;
      frame(ID_B, 1'b0, 1'b0, 16'h0033);
      check(32'(index_reg), 32'h33);
      frame(ID_A, 1'b0, 1'b0, 16'h0044);
      check(32'(index_reg), 32'h33);
      table_select_pin <= 1'b1;
   endtask : t_writes
   task automatic t_reads();
      row_position <= 8'h5C;
      frame(ID_A, 1'b0, 1'b1, 16'h0000);
      ahb(1'b0, OFS_RXDATA, 32'h0);
      check(rdata, 32'h5C00);
      check(32'(index_reg), 32'h33);
      frame(ID_A, 1'b1, 1'b1, 16'h0000);
      ahb(1'b0, OFS_RXDATA, 32'h0);
      check(rdata, 32'h0);
      check(32'(cmd_word_reg), 32'hBEEF);
   endtask : t_reads
   task automatic t_pin_reset();
      int n;
      n = resets_seen;
      ahb(1'b1, OFS_CTRL, 32'h8);
      poll(STAT_BUSY, 1'b0, 1000);
      check(32'(resets_seen - n >= RST_CYC - 4), 32'h1);
      check(32'(index_reg), 32'h0);
      check(32'(cmd_word_reg), 32'h0);
      frame(ID_A, 1'b1, 1'b0, 16'h0F0F);
      check(32'(cmd_word_reg), 32'h0F0F);
      check(32'(cmd_index_reg), 32'h0);
   endtask : t_pin_reset
   task automatic t_mid_reset();
      ahb(1'b1, OFS_CHIPADDR, {26'h0, ID_A});
      ahb(1'b1, OFS_TXDATA, 32'h5555);
      ahb(1'b1, OFS_CTRL, 32'h3);
      repeat (300) @(posedge hclk);
      check(32'(selected_reg), 32'h1);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      check(32'(in_reset_reg), 32'h1);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      check(32'(cmd_word_reg), 32'h0);
      check(32'(selected_reg), 32'h0);
      ahb(1'b0, OFS_STATUS, 32'h0);
      check(rdata, 32'h0);
      frame(ID_A, 1'b1, 1'b0, 16'hA55A);
      check(32'(cmd_word_reg), 32'hA55A);
   endtask : t_mid_reset
   // ===========================================================
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      table_select_pin = 1'b1;
      row_position = 8'h00;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      t_registers();
      t_writes();
      t_reads();
      t_pin_reset();
      t_mid_reset();
      give_verdict();
   end
endmodule : serial_command_port_test
`default_nettype wire
